// ---- logic/asf_alu.sv ----
// Purpose: 8-bit ALU producing result and five status flags
// Assumes: operands valid for the whole cycle
// Notes: subtraction adds the inverted second operand plus one
`timescale 1ns/100ps
module asf_alu
	import asf_pkg::*;
(
	asf_alu_if.alu bus
);
	logic [4:0] lo;
	logic [8:0] sum;
	logic [7:0] b_eff;
	logic c_eff;
	logic arith;

	// Operand shaping: subtract as two's complement add
	always_comb begin
		b_eff = bus.b;
		c_eff = 1'b0;
		arith = 1'b1;
		unique case (bus.op)
			ASF_OP_ADD: c_eff = 1'b0;
			ASF_OP_ADDC: c_eff = bus.cin;
			ASF_OP_SUB: begin
				b_eff = ~bus.b; // [RULE10]
				c_eff = 1'b1;
			end
			ASF_OP_SUBB: begin
				b_eff = ~bus.b; // [RULE10]
				c_eff = bus.cin;
			end
			ASF_OP_INC: begin
				b_eff = 8'h00;
				c_eff = 1'b1;
			end
			ASF_OP_DEC: begin
				b_eff = 8'hff;
				c_eff = 1'b0;
			end
			ASF_OP_NEG: begin
				b_eff = 8'h00;
				c_eff = 1'b1;
			end
			default: arith = 1'b0;
		endcase
	end

	// Adder split at the nibble so digit carry is the real bit-3 carry
	logic [7:0] a_eff;
	assign a_eff = (bus.op == ASF_OP_NEG) ? ~bus.a : bus.a;
	assign lo = {1'b0, a_eff[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
	assign sum = {1'b0, a_eff} + {1'b0, b_eff} + {8'h00, c_eff};

	// Result and flag generation
	always_comb begin
		bus.res = sum[7:0];
		bus.affects = 5'b10100;
		unique case (bus.op)
			ASF_OP_AND: bus.res = bus.a & bus.b;
			ASF_OP_OR: bus.res = bus.a | bus.b;
			ASF_OP_XOR: bus.res = bus.a ^ bus.b;
			ASF_OP_PASS: bus.res = bus.a;
			ASF_OP_CLR: begin
				bus.res = 8'h00;
				bus.affects = 5'b00100; // Clear touches zero only
			end
			ASF_OP_SWAP: begin
				bus.res = {bus.a[3:0], bus.a[7:4]};
				bus.affects = 5'b00000;
			end
			default: bus.affects = ASF_FLAG_MASK;
		endcase
		if (!arith && bus.op != ASF_OP_CLR && bus.op != ASF_OP_SWAP) begin
			bus.affects = 5'b10100;
		end
		bus.flags[ASF_BIT_NEG] = bus.res[7]; // [RULE5]
		bus.flags[ASF_BIT_OV] = (a_eff[7] == b_eff[7]) && (sum[7] != a_eff[7]); // [RULE6]
		bus.flags[ASF_BIT_ZERO] = (bus.res == 8'h00); // [RULE7]
		bus.flags[ASF_BIT_DC] = lo[4]; // [RULE8] [RULE10]
		bus.flags[ASF_BIT_CARRY] = sum[8]; // [RULE9] [RULE10]
	end
endmodule

// ---- logic/asf_alu_if.sv ----
// Purpose: carries operands and results between core and ALU
// Assumes: one clock, combinational ALU
// Notes: flag vector is {neg, ov, zero, dc, carry}
`timescale 1ns/100ps
interface asf_alu_if;
	import asf_pkg::*;
	asf_op_t op;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic [7:0] res;
	logic [4:0] flags;
	logic [4:0] affects;
	modport core (output op, output a, output b, output cin, input res, input flags, input affects);
	modport alu (input op, input a, input b, input cin, output res, output flags, output affects);
endinterface

// ---- logic/asf_pkg.sv ----
// Purpose: shared constants for the ALU status flag block
// Assumes: 8-bit data path, 12-bit data address space
// Notes: flag positions follow the status register layout
package asf_pkg;
	localparam int ASF_DATA_W = 8;
	localparam int ASF_ADDR_W = 12;
	localparam logic [11:0] ASF_ALU_FLAGS_ADDR = 12'hfd8;
	localparam int ASF_BIT_NEG = 4;
	localparam int ASF_BIT_OV = 3;
	localparam int ASF_BIT_ZERO = 2;
	localparam int ASF_BIT_DC = 1;
	localparam int ASF_BIT_CARRY = 0;
	localparam logic [4:0] ASF_FLAG_MASK = 5'h1f;
	localparam logic [4:0] ASF_FLAGS_RESET = 5'h00;
	// ALU operations
	typedef enum logic [3:0] {
		ASF_OP_ADD = 4'h0,
		ASF_OP_ADDC = 4'h1,
		ASF_OP_SUB = 4'h2,
		ASF_OP_SUBB = 4'h3,
		ASF_OP_AND = 4'h4,
		ASF_OP_OR = 4'h5,
		ASF_OP_XOR = 4'h6,
		ASF_OP_PASS = 4'h7,
		ASF_OP_CLR = 4'h8,
		ASF_OP_SWAP = 4'h9,
		ASF_OP_INC = 4'ha,
		ASF_OP_DEC = 4'hb,
		ASF_OP_NEG = 4'hc
	} asf_op_t;
	// Data addressing modes, one-hot
	typedef enum logic [4:0] {
		ASF_AM_INHERENT = 5'b00001,
		ASF_AM_LITERAL = 5'b00010,
		ASF_AM_DIRECT = 5'b00100,
		ASF_AM_INDIRECT = 5'b01000,
		ASF_AM_INDEXED = 5'b10000
	} asf_amode_t;
endpackage

// ---- logic/asf_status.sv ----
// Purpose: status flag register with ALU priority and addressing mode decode
// Assumes: one instruction completes per enabled clock edge
// Notes: upper three register bits are not stored
//
// Function
// [RULE1] Flag-affecting writes to status: ALU wins
// [RULE2] Clear of status sets zero only
// [RULE3] Software alters status via bit/swap/move only
// [RULE4] Bits 7-5 read zero, ignore writes
// [RULE5] Negative flag mirrors result bit 7
// [RULE6] Overflow flag flags signed sign flip
// [RULE7] Zero flag set on all-zero result
// [RULE8] Digit carry from low nibble on add/sub
// [RULE9] Carry from result MSB on add/sub
// [RULE10] Subtract by two's complement; carries invert borrows
// [RULE11] Status is an ordinary operand; reset unknown
// [RULE12] Inherent, literal, direct and indirect modes supported
// [RULE13] Indexed literal offset only with extended bit
// [RULE14] Program memory only via program counter
// [RULE15] Flags land with the instruction's result write
`timescale 1ns/100ps
module asf_status
	import asf_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire asf_op_t alu_op,
	input wire logic [7:0] opnd_a,
	input wire logic [7:0] opnd_b,
	input wire logic use_carry_in,
	input wire logic flag_update,
	input wire logic dest_write,
	input wire logic [11:0] dest_addr,
	input wire logic [7:0] move_data,
	input wire logic move_write,
	input wire logic [7:0] operand_field,
	input wire logic access_bank,
	input wire logic [3:0] bank_select,
	input wire logic [11:0] ptr_addr,
	input wire logic [7:0] offset_base,
	input wire logic has_operand,
	input wire logic is_literal,
	input wire logic is_indirect,
	input wire logic extended_set_config_bit,
	output logic [7:0] alu_flags,
	output logic [7:0] result_q,
	output logic result_valid_q,
	output logic [11:0] data_addr_q,
	output asf_amode_t addr_mode_q,
	output logic extended_active_q
);
	asf_alu_if alu_bus ();
	logic [4:0] flags_q;
	logic [4:0] flags_d;
	logic hits_status;
	logic alu_writes;
	logic [7:0] wdata;
	logic ext_s1_q;
	logic ext_s2_q;

	asf_alu u_alu (
		.bus(alu_bus.alu)
	);

	// Drive the ALU
	assign alu_bus.op = alu_op;
	assign alu_bus.a = opnd_a;
	assign alu_bus.b = opnd_b;
	assign alu_bus.cin = use_carry_in ? flags_q[ASF_BIT_CARRY] : 1'b0;

	// Status is a normal data address like any other
	assign hits_status = (dest_addr == ASF_ALU_FLAGS_ADDR); // [RULE11]
	assign wdata = move_write ? move_data : alu_bus.res;

	// Any flag-affecting instruction blocks the explicit write to all five flags
	assign alu_writes = instr_valid && flag_update && !move_write && (alu_bus.affects != 5'h00); // [RULE1]

	// Explicit write only for non-flag instructions; ALU bits then land per bit
	always_comb begin
		flags_d = flags_q;
		if (instr_valid && (dest_write || move_write) && hits_status && !alu_writes) begin
			flags_d = wdata[4:0]; // [RULE3] [RULE4]
		end
		if (alu_writes) begin
			for (int i = 0; i < 5; i++) begin
				if (alu_bus.affects[i]) begin
					flags_d[i] = alu_bus.flags[i]; // [RULE1] [RULE2]
				end
			end
		end
	end

	// Flags have no reset: power-on state is unknown by design
	always_ff @(posedge clock) begin
		flags_q <= flags_d; // [RULE11] [RULE15]
	end

	// Read view: upper three bits are hardwired zero
	assign alu_flags = {3'b000, flags_q}; // [RULE4]

	// Result register written on the same edge as the flags
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= 8'h00;
			result_valid_q <= 1'b0;
		end else begin
			result_valid_q <= instr_valid; // [RULE15]
			if (instr_valid) begin
				result_q <= wdata;
			end
		end
	end

	// Configuration bit comes from fuse logic; synchronise it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			extended_active_q <= 1'b0;
		end else begin
			ext_s1_q <= extended_set_config_bit;
			ext_s2_q <= ext_s1_q;
			extended_active_q <= ext_s2_q; // [RULE13]
		end
	end

	// Data address and mode decode; program memory never reached here
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_mode_q <= ASF_AM_INHERENT;
			data_addr_q <= 12'h000;
		end else if (instr_valid) begin
			if (!has_operand) begin
				addr_mode_q <= ASF_AM_INHERENT; // [RULE12]
				data_addr_q <= 12'h000;
			end else if (is_literal) begin
				addr_mode_q <= ASF_AM_LITERAL; // [RULE12]
				data_addr_q <= 12'h000;
			end else if (is_indirect) begin
				addr_mode_q <= ASF_AM_INDIRECT; // [RULE12]
				data_addr_q <= ptr_addr;
			end else if (extended_active_q && !access_bank && operand_field < 8'h60) begin
				// Low access-bank operands become offsets from the pointer
				addr_mode_q <= ASF_AM_INDEXED; // [RULE13]
				data_addr_q <= 12'(ptr_addr + {4'h0, offset_base} + {4'h0, operand_field});
			end else if (!access_bank) begin
				addr_mode_q <= ASF_AM_DIRECT; // [RULE12] [RULE14]
				data_addr_q <= (operand_field < 8'h60) ? {4'h0, operand_field} : {4'hf, operand_field};
			end else begin
				addr_mode_q <= ASF_AM_DIRECT; // [RULE12]
				data_addr_q <= {bank_select, operand_field};
			end
		end
	end
endmodule

// ---- verif/asf_status_asserts.sv ----
// Purpose: flag and timing checks at the asf_status ports
// Assumes: flags are loaded before they are relied on
// Notes: moves bypass the ALU flags, so they are excluded
`timescale 1ns/100ps
module asf_status_chk
	import asf_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire asf_op_t alu_op,
	input wire logic [7:0] opnd_a,
	input wire logic [7:0] opnd_b,
	input wire logic flag_update,
	input wire logic move_write,
	input wire logic [7:0] alu_flags,
	input wire logic result_valid_q,
	input wire asf_amode_t addr_mode_q,
	input wire logic extended_active_q
);
	logic [8:0] s;
	logic [4:0] n;
	logic fl;
	logic add;
	// Reference sums kept wide so the carries survive
	assign s = {1'b0, opnd_a} + {1'b0, opnd_b};
	assign n = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]};
	assign fl = instr_valid && flag_update && !move_write;
	assign add = fl && alu_op == ASF_OP_ADD;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_top; alu_flags[7:5] == 3'h0; endproperty
	a_top: assert property (p_top) else $error("upper bits set");
	property p_vld; 1 |=> result_valid_q == $past(instr_valid); endproperty
	a_vld: assert property (p_vld) else $error("result late");
	property p_c; add |=> alu_flags[0] == $past(s[8]); endproperty
	a_c: assert property (p_c) else $error("carry wrong");
	property p_dc; add |=> alu_flags[1] == $past(n[4]); endproperty
	a_dc: assert property (p_dc) else $error("digit carry wrong");
	property p_z; add |=> alu_flags[2] == ($past(s[7:0]) == 8'h00); endproperty
	a_z: assert property (p_z) else $error("zero wrong");
	property p_ov; add |=> alu_flags[4:3] == $past({s[7], opnd_a[7] == opnd_b[7] && s[7] != opnd_a[7]}); endproperty
	a_ov: assert property (p_ov) else $error("sign or overflow wrong");
	property p_sub; fl && alu_op == ASF_OP_SUB |=> alu_flags[0] == $past(opnd_a >= opnd_b); endproperty
	a_sub: assert property (p_sub) else $error("borrow wrong");
	property p_ext; instr_valid && !extended_active_q |=> addr_mode_q != ASF_AM_INDEXED; endproperty
	a_ext: assert property (p_ext) else $error("indexed without ext");
endmodule
bind asf_status asf_status_chk u_asf_status_chk (.*);

// ---- verif/testbench.sv ----
// Purpose: directed instruction sequences for asf_status
// Assumes: inputs change on the falling edge
// Notes: flags are loaded by a move first, as they reset unknown
`timescale 1ns/100ps
module testbench;
	import asf_pkg::*;
	logic clock, rst_n, instr_valid, use_carry_in, flag_update, dest_write, move_write;
	asf_op_t alu_op;
	logic [7:0] opnd_a, opnd_b, move_data, operand_field, offset_base, alu_flags, result_q;
	logic [11:0] dest_addr, ptr_addr, data_addr_q;
	logic [3:0] bank_select;
	logic access_bank, has_operand, is_literal, is_indirect, extended_set_config_bit;
	logic result_valid_q, extended_active_q;
	asf_amode_t addr_mode_q;
	int bad_count, tests_run;
	asf_op_t ops[6] = '{ASF_OP_ADD, ASF_OP_ADD, ASF_OP_ADD, ASF_OP_ADD, ASF_OP_SUB, ASF_OP_SUB};
	logic [7:0] av[6] = '{8'h7f, 8'hff, 8'h80, 8'h12, 8'h05, 8'h03};
	logic [7:0] bv[6] = '{8'h01, 8'h01, 8'h80, 8'h34, 8'h03, 8'h05};
	logic [7:0] fx[6] = '{8'h1a, 8'h07, 8'h0d, 8'h00, 8'h03, 8'h10};
	logic [7:0] rx[6] = '{8'h80, 8'h00, 8'h00, 8'h46, 8'h02, 8'hfe};
	logic [2:0] am_in[4] = '{3'h0, 3'h6, 3'h5, 3'h4};
	asf_amode_t am_ex[4] = '{ASF_AM_INHERENT, ASF_AM_LITERAL, ASF_AM_INDIRECT, ASF_AM_DIRECT};
	asf_status u_asf_status (.*);
	// Free-running clock
	initial begin
		clock = 0;
		forever #25 clock = ~clock;
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One instruction, taken at the rising edge between two falling edges
	task automatic run(input asf_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [11:0] d, input logic mv);
		alu_op = op;
		opnd_a = a;
		opnd_b = b;
		move_data = a;
		dest_addr = d;
		move_write = mv;
		flag_update = !mv;
		instr_valid = 1;
		@(negedge clock);
		instr_valid = 0;
		chk(result_valid_q, 1);
	endtask
	task automatic close_out();
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (2000) @(posedge clock);
		bad_count++;
		close_out();
	end
	initial begin
		{instr_valid, use_carry_in, flag_update, move_write, access_bank, is_literal, is_indirect} = 7'h0;
		{extended_set_config_bit, has_operand, dest_write, rst_n} = 4'h6;
		{opnd_a, opnd_b, move_data, operand_field, offset_base} = 40'h0;
		{dest_addr, ptr_addr, bank_select} = 28'h0001000;
		alu_op = ASF_OP_PASS;
		repeat (10) @(negedge clock);
		rst_n = 1;
		run(ASF_OP_PASS, 8'hff, 8'h00, ASF_ALU_FLAGS_ADDR, 1);
		chk(alu_flags, 8'h1f);
		// First row targets status itself: the ALU flags must win
		for (int i = 0; i < 6; i++) begin
			run(ops[i], av[i], bv[i], i == 0 ? ASF_ALU_FLAGS_ADDR : 12'h020, 0);
			chk(alu_flags, fx[i]);
			chk(result_q, rx[i]);
		end
		run(ASF_OP_PASS, 8'hfa, 8'h00, ASF_ALU_FLAGS_ADDR, 1);
		run(ASF_OP_CLR, 8'h00, 8'h00, ASF_ALU_FLAGS_ADDR, 0);
		chk(alu_flags, 8'h1e);
		// Swap touches no flag, so its write to status lands in full
		run(ASF_OP_SWAP, 8'h1b, 8'h00, ASF_ALU_FLAGS_ADDR, 0);
		chk(alu_flags, 8'h11);
		chk(result_q, 8'hb1);
		// Mid-run reset: flags keep their value, the rest returns to idle
		rst_n = 0;
		@(negedge clock);
		rst_n = 1;
		chk(alu_flags, 8'h11);
		chk(result_q, 8'h00);
		chk(result_valid_q, 0);
		chk(addr_mode_q, ASF_AM_INHERENT);
		operand_field = 8'h10;
		offset_base = 8'h04;
		for (int i = 0; i < 4; i++) begin
			{has_operand, is_literal, is_indirect} = am_in[i];
			run(ASF_OP_PASS, 8'h00, 8'h00, 12'h020, 1);
			chk(addr_mode_q, am_ex[i]);
		end
		chk(data_addr_q, 12'h010);
		extended_set_config_bit = 1;
		repeat (5) @(negedge clock);
		chk(extended_active_q, 1);
		run(ASF_OP_PASS, 8'h00, 8'h00, 12'h020, 1);
		chk(addr_mode_q, ASF_AM_INDEXED);
		chk(data_addr_q, 12'h114);
		close_out();
	end
endmodule
